// File: core/audio_page_chain_dma.sv
// Overview of operation
// (RL1) each direction holds a current page address and a next page address
// (RL2) playback and record have separate current/next pairs
// (RL3) at page end continue at next address and interrupt for another
// (RL4) advancing copies next address into the current register
// (RL5) software writes only next registers; current writable for test only
// (RL6) engine idle keeps interrupts off; software enables them to start
// (RL7) enabled with no valid next address interrupts at once
// (RL8) next written with no current page moves straight to current, interrupts again
// (RL9) software disables interrupts only after final pages of both directions
// (RL10) playback reads filled pages, record writes captured samples to pages
// (RL11) playback and record start and stop together
// (RL12) one bus mastership moves both playback and record words
// (RL13) playback address written first; record address write starts both
// (RL14) software services only directions whose request flag is set
// (RL15) current address points to next access and only increases in page
// (RL16) software avoids the current word; word minus four is complete
// (RL17) current at first page word means page untouched, previous complete
// (RL18) playback pointer keeps the same progress meaning as record
// (RL19) current register read as one full word, never split
// (RL20) sample layout follows control register format settings; I_FORMAT and I_STEREO are unused, sample words pass unchanged
// (RL21) pages are 4K aligned; low twelve next address bits ignored
// (RL22) codec control rewritten only while both active flags are zero
// (RL23) registers 32 bits wide, byte and half word accesses accepted
// (RL24) current advances four bytes per word; page end completes page
// (RL25) interrupt held while enabled and any direction lacks next address
`timescale 1ns/1ps
`default_nettype none
module audio_page_chain_dma
	import page_dma_pkg::*;
(
	input  wire logic                    I_CORE_CLK,
	input  wire logic                    I_RESETN,
	input  wire logic                    I_REG_SEL,
	input  wire logic                    I_REG_WR,
	input  wire logic [REG_OFF_W-1:0]    I_REG_ADDR,
	input  wire logic [3:0]              I_REG_BE,
	input  wire logic [DATA_W-1:0]       I_REG_WDATA,
	output logic      [DATA_W-1:0]       O_REG_RDATA,
	input  wire logic [1:0]              I_FORMAT,
	input  wire logic                    I_STEREO,
	input  wire logic                    I_SAMPLE_TICK,
	input  wire logic [DATA_W-1:0]       I_REC_SAMPLE,
	output logic      [DATA_W-1:0]       O_PLAY_SAMPLE,
	output logic                         O_PLAY_SAMPLE_VALID,
	output logic                         O_BUS_REQ,
	input  wire logic                    I_BUS_GNT,
	output logic      [ADDR_W-1:0]       O_MEM_ADDR,
	output logic                         O_MEM_WR,
	output logic                         O_MEM_RD,
	output logic      [DATA_W-1:0]       O_MEM_WDATA,
	input  wire logic [DATA_W-1:0]       I_MEM_RDATA,
	input  wire logic                    I_MEM_ACK,
	output logic                         O_IRQ,
	output logic                         O_PLAYBACK_ACTIVE_FLAG,
	output logic                         O_RECORD_ACTIVE_FLAG
);
	typedef enum logic [2:0] {
		S_IDLE,
		S_REQ,
		S_PLAY,
		S_REC,
		S_DONE
	} xfer_e;

	xfer_e             state;
	xfer_e             next_state;
	logic              irq_enable;
	logic              run;
	logic [DATA_W-1:0] rec_hold;
	logic              pending;
	logic [ADDR_W-1:0] p_cur;
	logic [ADDR_W-1:0] p_next;
	logic [ADDR_W-1:0] r_cur;
	logic [ADDR_W-1:0] r_next;
	logic              p_cur_valid;
	logic              p_next_valid;
	logic              r_cur_valid;
	logic              r_next_valid;
	logic              p_done;
	logic              r_done;
	logic [DATA_W-1:0] wr_merged;
	logic [DATA_W-1:0] old_word;
	logic [DATA_W-1:0] status_word;
	logic              wr_status;
	logic              wr_pnext;
	logic              wr_pcur;
	logic              wr_rnext;
	logic              wr_rcur;
	logic              rec_start;
	logic              both_valid;
	logic              advance;
	logic              p_want;
	logic              r_want;

	function automatic logic hit(input logic [REG_OFF_W-1:0] addr, input logic [REG_OFF_W-1:0] off);
		hit = I_REG_SEL && I_REG_WR && (addr == off);
	endfunction : hit

	// register decode
	assign wr_status = hit(I_REG_ADDR, OFF_STATUS);
	assign wr_pnext  = hit(I_REG_ADDR, OFF_PNEXT);
	assign wr_pcur   = hit(I_REG_ADDR, OFF_PCUR); // see (RL5)
	assign wr_rnext  = hit(I_REG_ADDR, OFF_RNEXT);
	assign wr_rcur   = hit(I_REG_ADDR, OFF_RCUR);

	assign old_word = (I_REG_ADDR == OFF_STATUS) ? status_word :
	                  (I_REG_ADDR == OFF_PNEXT)  ? p_next :
	                  (I_REG_ADDR == OFF_PCUR)   ? p_cur :
	                  (I_REG_ADDR == OFF_RNEXT)  ? r_next :
	                  (I_REG_ADDR == OFF_RCUR)   ? r_cur : '0;

	word_lane_merge u_merge (
		.i_old    (old_word),
		.i_new    (I_REG_WDATA),
		.i_be     (I_REG_BE),
		.o_merged (wr_merged)
	);

	// record address write starts both directions
	assign rec_start  = wr_rnext && !run; // see (RL13) (RL11)
	assign both_valid = p_cur_valid && r_cur_valid;
	// one advance step moves both pointers together
	assign advance = (state == S_DONE); // see (RL11) (RL18)

	page_addr_pair u_play (
		.i_clk        (I_CORE_CLK),
		.i_resetn     (I_RESETN),
		.i_next_wr    (wr_pnext),
		.i_cur_wr     (wr_pcur),
		.i_wdata      (wr_merged),
		.i_load_empty (run || rec_start),
		.i_advance    (advance),
		.o_cur        (p_cur),
		.o_next       (p_next),
		.o_cur_valid  (p_cur_valid),
		.o_next_valid (p_next_valid),
		.o_page_done  (p_done)
	); // see (RL2)

	page_addr_pair u_rec (
		.i_clk        (I_CORE_CLK),
		.i_resetn     (I_RESETN),
		.i_next_wr    (wr_rnext),
		.i_cur_wr     (wr_rcur),
		.i_wdata      (wr_merged),
		.i_load_empty (run || rec_start),
		.i_advance    (advance),
		.o_cur        (r_cur),
		.o_next       (r_next),
		.o_cur_valid  (r_cur_valid),
		.o_next_valid (r_next_valid),
		.o_page_done  (r_done)
	); // see (RL2)

	// request flags and interrupt
	assign p_want = !p_next_valid;
	assign r_want = !r_next_valid;
	assign O_IRQ  = irq_enable && (p_want || r_want); // see (RL7) (RL25) (RL3) (RL8)

	assign status_word = {irq_enable, {(DATA_W-1-ST_PN_BIT-1){1'b0}}, p_want,
	                      O_PLAYBACK_ACTIVE_FLAG, {(ST_PC_BIT-ST_RN_BIT-1){1'b0}}, r_want,
	                      O_RECORD_ACTIVE_FLAG};

	// full word read path, never split
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_REG_RDATA <= '0;
		end else if (I_REG_SEL && !I_REG_WR) begin
			O_REG_RDATA <= old_word; // see (RL19)
		end
	end

	// enable control; idle comes up disabled
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			irq_enable <= 1'b0; // see (RL6)
		end else if (wr_status && I_REG_BE[3]) begin
			irq_enable <= I_REG_WDATA[ST_IE_BIT];
		end
	end

	// shared run flag stops both at once when disabled; it stays set when pages run out
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			run <= 1'b0;
		end else if (rec_start && irq_enable) begin
			run <= 1'b1; // see (RL11) (RL13)
		end else if (!irq_enable || (advance && !both_valid)) begin
			run <= 1'b0;
		end
	end

	// both flags rise together once both current pages are loaded
	assign O_PLAYBACK_ACTIVE_FLAG = run && both_valid; // see (RL11)
	assign O_RECORD_ACTIVE_FLAG   = run && both_valid; // see (RL11)

	// sample pacing
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			pending  <= 1'b0;
			rec_hold <= '0;
		end else if (I_SAMPLE_TICK && run) begin
			pending  <= 1'b1;
			rec_hold <= I_REC_SAMPLE; // see (RL20)
		end else if (state == S_DONE) begin
			pending <= 1'b0;
		end
	end

	// one mastership: read a playback word, then write a record word
	always_comb begin
		next_state = state;
		case (state)
			S_IDLE: begin
				if (pending && run && both_valid) begin
					next_state = S_REQ;
				end
			end
			S_REQ: begin
				if (I_BUS_GNT) begin
					next_state = S_PLAY; // see (RL12)
				end
			end
			S_PLAY: begin
				if (I_MEM_ACK) begin
					next_state = S_REC;
				end
			end
			S_REC: begin
				if (I_MEM_ACK) begin
					next_state = S_DONE;
				end
			end
			S_DONE: begin
				next_state = S_IDLE;
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			state <= S_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign O_BUS_REQ   = (state == S_REQ) || (state == S_PLAY) || (state == S_REC);
	assign O_MEM_RD    = (state == S_PLAY); // see (RL10)
	assign O_MEM_WR    = (state == S_REC); // see (RL10)
	assign O_MEM_ADDR  = (state == S_REC) ? r_cur : p_cur; // see (RL15)
	assign O_MEM_WDATA = rec_hold;

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_PLAY_SAMPLE       <= '0;
			O_PLAY_SAMPLE_VALID <= 1'b0;
		end else begin
			O_PLAY_SAMPLE_VALID <= (state == S_PLAY) && I_MEM_ACK;
			if ((state == S_PLAY) && I_MEM_ACK) begin
				O_PLAY_SAMPLE <= I_MEM_RDATA;
			end
		end
	end
endmodule : audio_page_chain_dma
`default_nettype wire

// File: core/page_dma_pkg.sv
package page_dma_pkg;
	localparam int unsigned ADDR_W        = 32;
	localparam int unsigned DATA_W        = 32;
	localparam int unsigned PAGE_BITS     = 12;
	localparam int unsigned WORD_BYTES    = 4;
	localparam int unsigned REG_OFF_W     = 6;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
	localparam logic [PAGE_BITS-1:0] PAGE_LOW_ZERO = 12'h000;
	localparam logic [PAGE_BITS-1:0] LAST_WORD_OFF = 12'hFFC;
	localparam logic [PAGE_BITS-1:0] WORD_STEP = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h0000_0004;
	// register offsets
	localparam logic [REG_OFF_W-1:0] OFF_STATUS   = 6'h0C;
	localparam logic [REG_OFF_W-1:0] OFF_PNEXT    = 6'h10;
	localparam logic [REG_OFF_W-1:0] OFF_PCUR     = 6'h14;
	localparam logic [REG_OFF_W-1:0] OFF_RNEXT    = 6'h18;
	localparam logic [REG_OFF_W-1:0] OFF_RCUR     = 6'h1C;
	// status bit positions
	localparam int unsigned ST_IE_BIT     = 31;
	localparam int unsigned ST_PN_BIT     = 9;
	localparam int unsigned ST_RN_BIT     = 1;
	localparam int unsigned ST_PC_BIT     = 8;
	localparam int unsigned ST_RC_BIT     = 0;
	typedef enum logic [1:0] {
		DIR_PLAY,
		DIR_REC
	} dir_e;
endpackage : page_dma_pkg

// File: core/page_addr_pair.sv
`timescale 1ns/1ps
`default_nettype none
module page_addr_pair
	import page_dma_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_resetn,
	input  wire logic              i_next_wr,
	input  wire logic              i_cur_wr,
	input  wire logic [ADDR_W-1:0] i_wdata,
	input  wire logic              i_load_empty,
	input  wire logic              i_advance,
	output logic      [ADDR_W-1:0] o_cur,
	output logic      [ADDR_W-1:0] o_next,
	output logic                   o_cur_valid,
	output logic                   o_next_valid,
	output logic                   o_page_done
);
	logic              at_last;
	logic              chain;
	logic [ADDR_W-1:0] next_cur;
	logic              next_cur_valid;
	logic              next_next_valid;
	logic [ADDR_W-1:0] page_base;

	assign page_base = {i_wdata[ADDR_W-1:PAGE_BITS], PAGE_LOW_ZERO}; // see (RL21)
	assign at_last   = o_cur[PAGE_BITS-1:0] == LAST_WORD_OFF; // see (RL24)
	assign o_page_done = i_advance && at_last;
	// chaining on page end or on load into an empty slot
	assign chain = (o_page_done || (i_load_empty && !o_cur_valid)) && o_next_valid; // see (RL3) (RL8)

	always_comb begin
		next_cur       = o_cur;
		next_cur_valid = o_cur_valid;
		next_next_valid = o_next_valid;
		if (i_advance && !at_last) begin
			next_cur = o_cur + ADDR_STEP; // see (RL15) (RL24)
		end else if (o_page_done && !o_next_valid) begin
			next_cur_valid = 1'b0;
		end
		if (chain) begin
			next_cur        = o_next; // see (RL4) (RL17)
			next_cur_valid  = 1'b1;
			next_next_valid = 1'b0;
		end
		if (i_cur_wr) begin
			next_cur       = {i_wdata[ADDR_W-1:2], 2'b00};
			next_cur_valid = 1'b1;
		end
		if (i_next_wr) begin
			next_next_valid = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_cur        <= ADDR_RESET;
			o_next       <= ADDR_RESET;
			o_cur_valid  <= 1'b0;
			o_next_valid <= 1'b0;
		end else begin
			o_cur        <= next_cur; // see (RL1)
			o_cur_valid  <= next_cur_valid;
			o_next_valid <= next_next_valid;
			if (i_next_wr) begin
				o_next <= page_base;
			end
		end
	end
endmodule : page_addr_pair
`default_nettype wire

// File: core/word_lane_merge.sv
`timescale 1ns/1ps
`default_nettype none
module word_lane_merge
	import page_dma_pkg::*;
(
	input  wire logic [DATA_W-1:0] i_old,
	input  wire logic [DATA_W-1:0] i_new,
	input  wire logic [3:0]        i_be,
	output logic      [DATA_W-1:0] o_merged
);
	// byte lane merge for partial writes
	assign o_merged = {i_be[3] ? i_new[31:24] : i_old[31:24],
	                   i_be[2] ? i_new[23:16] : i_old[23:16],
	                   i_be[1] ? i_new[15:8]  : i_old[15:8],
	                   i_be[0] ? i_new[7:0]   : i_old[7:0]}; // see (RL23)
endmodule : word_lane_merge
`default_nettype wire

// File: testbench/page_dma_sva.sv
`timescale 1ns/1ps
`default_nettype none
module page_dma_sva
	import page_dma_pkg::*;
(
	input wire logic              I_CORE_CLK,
	input wire logic              I_RESETN,
	input wire logic              O_BUS_REQ,
	input wire logic              I_BUS_GNT,
	input wire logic [ADDR_W-1:0] O_MEM_ADDR,
	input wire logic              O_MEM_RD,
	input wire logic              O_MEM_WR,
	input wire logic [DATA_W-1:0] O_MEM_WDATA,
	input wire logic              I_MEM_ACK,
	input wire logic              O_PLAY_SAMPLE_VALID,
	input wire logic              O_PLAYBACK_ACTIVE_FLAG,
	input wire logic              O_RECORD_ACTIVE_FLAG
);
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RESETN);
	sequence s_rd_done; O_MEM_RD && I_MEM_ACK; endsequence
	sequence s_wr_done; O_MEM_WR && I_MEM_ACK; endsequence
	property p_rd_to_wr; s_rd_done |=> O_MEM_WR; endproperty
	property p_in_master; (O_MEM_RD || O_MEM_WR) |-> O_BUS_REQ && I_BUS_GNT; endproperty
	property p_rd_hold; O_MEM_RD && !I_MEM_ACK |=> O_MEM_RD && $stable(O_MEM_ADDR); endproperty
	property p_wr_hold;
		O_MEM_WR && !I_MEM_ACK |=> O_MEM_WR && $stable(O_MEM_WDATA) && $stable(O_MEM_ADDR);
	endproperty
	property p_aligned; (O_MEM_RD || O_MEM_WR) |-> O_MEM_ADDR[1:0] == 2'h0; endproperty
	property p_sync; O_PLAYBACK_ACTIVE_FLAG == O_RECORD_ACTIVE_FLAG; endproperty
	property p_pulse; O_PLAY_SAMPLE_VALID |=> !O_PLAY_SAMPLE_VALID; endproperty
	property p_valid; s_rd_done |=> O_PLAY_SAMPLE_VALID; endproperty
	a_rd_to_wr: assert property (p_rd_to_wr) else $error("no write after read");
	a_in_master: assert property (p_in_master) else $error("access outside grant");
	a_rd_hold: assert property (p_rd_hold) else $error("read dropped");
	a_wr_hold: assert property (p_wr_hold) else $error("write dropped");
	a_aligned: assert property (p_aligned) else $error("unaligned access");
	a_sync: assert property (p_sync) else $error("flags differ");
	a_pulse: assert property (p_pulse) else $error("valid too long");
	a_valid: assert property (p_valid) else $error("no playback word");
endmodule : page_dma_sva
bind audio_page_chain_dma page_dma_sva u_sva (.I_CORE_CLK(I_CORE_CLK), .I_RESETN(I_RESETN),
	.O_BUS_REQ(O_BUS_REQ), .I_BUS_GNT(I_BUS_GNT), .O_MEM_ADDR(O_MEM_ADDR), .O_MEM_RD(O_MEM_RD),
	.O_MEM_WR(O_MEM_WR), .O_MEM_WDATA(O_MEM_WDATA), .I_MEM_ACK(I_MEM_ACK),
	.O_PLAY_SAMPLE_VALID(O_PLAY_SAMPLE_VALID), .O_PLAYBACK_ACTIVE_FLAG(O_PLAYBACK_ACTIVE_FLAG),
	.O_RECORD_ACTIVE_FLAG(O_RECORD_ACTIVE_FLAG));
`default_nettype wire

// File: testbench/host_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_mem_model (
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic [1:0]  i_stall,
	input  wire logic        i_req,
	input  wire logic        i_rd,
	input  wire logic        i_wr,
	input  wire logic [31:0] i_addr,
	input  wire logic [31:0] i_wdata,
	output logic             o_gnt,
	output logic             o_ack,
	output logic [31:0]      o_rdata,
	output logic [31:0]      o_last_addr,
	output logic [31:0]      o_last_data
);
	logic [1:0]  cnt;
	logic [31:0] cyc;
	// whole word per beat; idle data keeps changing
	assign o_rdata = o_ack ? {i_addr[15:0], ~i_addr[15:0]} : ~cyc;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			{cnt, cyc, o_gnt, o_ack, o_last_addr, o_last_data} <= '0;
		end else begin
			cyc <= cyc + 32'h1;
			o_gnt <= i_req;
			o_ack <= 1'b0;
			if ((i_rd || i_wr) && !o_ack) begin
				cnt <= (cnt == i_stall) ? 2'h0 : cnt + 2'h1;
				o_ack <= (cnt == i_stall);
			end
			if (o_ack && i_wr) begin
				o_last_addr <= i_addr;
				o_last_data <= i_wdata;
			end
		end
	end
endmodule : host_mem_model
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import page_dma_pkg::*;
	logic clk, rstn, sel, wr, tick, gnt, ack, req, mrd, mwr, irq, pa, ra, pv;
	logic [5:0]  off;
	logic [3:0]  be;
	logic [1:0]  stall;
	logic [31:0] wd, rd, rs, ps, mrdata, mwd, ma, lwa, lwd, d;
	int          err_count, compares, cyc;
	audio_page_chain_dma DUT (.I_CORE_CLK(clk), .I_RESETN(rstn), .I_REG_SEL(sel), .I_REG_WR(wr),
		.I_REG_ADDR(off), .I_REG_BE(be), .I_REG_WDATA(wd), .O_REG_RDATA(rd), .I_FORMAT(2'h0),
		.I_STEREO(1'b1), .I_SAMPLE_TICK(tick), .I_REC_SAMPLE(rs), .O_PLAY_SAMPLE(ps),
		.O_PLAY_SAMPLE_VALID(pv), .O_BUS_REQ(req), .I_BUS_GNT(gnt), .O_MEM_ADDR(ma), .O_MEM_WR(mwr),
		.O_MEM_RD(mrd), .O_MEM_WDATA(mwd), .I_MEM_RDATA(mrdata), .I_MEM_ACK(ack), .O_IRQ(irq),
		.O_PLAYBACK_ACTIVE_FLAG(pa), .O_RECORD_ACTIVE_FLAG(ra));
	host_mem_model u_host (.i_clk(clk), .i_resetn(rstn), .i_stall(stall), .i_req(req), .i_rd(mrd),
		.i_wr(mwr), .i_addr(ma), .i_wdata(mwd), .o_gnt(gnt), .o_ack(ack), .o_rdata(mrdata),
		.o_last_addr(lwa), .o_last_data(lwd));
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			final_report();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task reg_wr(input logic [5:0] o, input logic [31:0] v, input logic [3:0] b);
		@(posedge clk); #1 {sel, wr, off, wd, be} = {2'b11, o, v, b};
		@(posedge clk); #1 {sel, wr} = 2'b00;
		@(posedge clk); #1;
	endtask : reg_wr
	task reg_rd(input logic [5:0] o, input logic [31:0] exp);
		@(posedge clk); #1 {sel, wr, off} = {2'b10, o};
		@(posedge clk); #1 sel = 0;
		chk(rd, exp);
	endtask : reg_rd
	task xfer(input logic [31:0] s);
		int n;
		rs = s;
		n = 0;
		@(posedge clk); #1 tick = 1;
		@(posedge clk); #1 tick = 0;
		while (pv !== 1'b1 && n < 60) begin
			@(posedge clk); #1 n++;
		end
		chk(pv, 1);
		while (req === 1'b1 && n < 60) begin
			@(posedge clk); #1 n++;
		end
		@(posedge clk); #1;
	endtask : xfer
	task t_start;
		chk({irq, pa, ra}, 0);
		reg_wr(OFF_STATUS, 32'h8000_0000, 4'h8);
		chk(irq, 1);
		@(posedge clk); #1 {sel, wr, off} = {2'b10, OFF_STATUS};
		@(posedge clk); #1 sel = 0;
		chk(rd & 32'h8000_0303, 32'h8000_0202);
		reg_wr(OFF_PNEXT, 32'h0001_0ABC, 4'hF);
		chk(pa, 0);
		reg_wr(OFF_RNEXT, 32'h0002_0123, 4'hF);
		chk({irq, pa, ra}, 3'h7);
		reg_rd(OFF_PCUR, 32'h0001_0000);
		reg_rd(OFF_RCUR, 32'h0002_0000);
		$display("test start done");
	endtask : t_start
	task t_move;
		xfer(32'h1234_5678);
		chk(ps, 32'h0000_FFFF);
		chk(lwa, 32'h0002_0000);
		chk(lwd, 32'h1234_5678);
		reg_rd(OFF_PCUR, 32'h0001_0004);
		reg_rd(OFF_RCUR, 32'h0002_0004);
		reg_wr(OFF_PNEXT, 32'h0003_0FFF, 4'hF);
		chk(irq, 1);
		reg_wr(OFF_RNEXT, 32'h0004_0000, 4'hF);
		chk(irq, 0);
		$display("test move done");
	endtask : t_move
	task t_chain;
		stall = 2'h3;
		reg_wr(OFF_PCUR, 32'h0000_00FC, 4'h1);
		reg_wr(OFF_PCUR, 32'h0000_0F00, 4'h2);
		reg_rd(OFF_PCUR, 32'h0001_0FFC);
		reg_wr(OFF_RCUR, 32'h0002_0FFC, 4'hF);
		xfer(32'hCAFE_0001);
		chk(ps, 32'h0FFC_F003);
		chk(lwa, 32'h0002_0FFC);
		reg_rd(OFF_PCUR, 32'h0003_0000);
		reg_rd(OFF_RCUR, 32'h0004_0000);
		chk(irq, 1);
		xfer(32'h0000_00A5);
		chk(lwa, 32'h0004_0000);
		$display("test chain done");
	endtask : t_chain
	task t_stop;
		reg_wr(OFF_STATUS, 32'h0000_0000, 4'h8);
		chk({irq, pa, ra}, 0);
		@(posedge clk); #1 tick = 1;
		@(posedge clk); #1 tick = 0;
		repeat (3) @(posedge clk);
		#1 chk(req, 0);
		reg_rd(6'h20, 32'h0000_0000);
		$display("test stop done");
	endtask : t_stop
	task final_report;
		$display("comparisons %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	initial begin
		{rstn, sel, wr, tick, off, be, wd, rs, stall} = '0;
		repeat (2) @(posedge clk);
		#1 rstn = 1;
		t_start();
		t_move();
		t_chain();
		t_stop();
		final_report();
	end
endmodule : tb
`default_nettype wire
